/* hdl/safety_sup_defines.svh */
`ifndef SAFETY_SUP_DEFINES_SVH
`define SAFETY_SUP_DEFINES_SVH
// register byte offsets
`define OFF_CTRL        12'h000
`define OFF_STATUS      12'h004
`define OFF_IRQ_STAT    12'h008
`define OFF_IRQ_MASK    12'h00C
`define OFF_DLY_RAMP    12'h010
`define OFF_DLY_DIR     12'h014
`define OFF_DLY_BRAKE   12'h018
`define OFF_DLY_POS     12'h01C
`define OFF_EARLY_TIME  12'h020
`define OFF_ENC_POS_TOL 12'h024
`define OFF_ENC_SPD_TOL 12'h028
`define OFF_LIM_STAND   12'h02C
`define OFF_LIM_LS4     12'h030
`define OFF_LIM_LS3     12'h034
`define OFF_LIM_LS2     12'h038
`define OFF_LIM_LS1     12'h03C
`define OFF_LIM_MAX     12'h040
`define OFF_LIM_NORM    12'h044
`define OFF_MAXP_LO     12'h048
`define OFF_LIMP_LO     12'h04C
`define OFF_LIMP_HI     12'h050
`define OFF_MAXP_HI     12'h054
`define OFF_FAULT_LOG   12'h058
// ctrl fields
`define CTRL_CFG_VALID  0
`define CTRL_FW_FAULT   1
// irq status bit positions
`define IRQ_FAILSAFE    0
`define IRQ_SPEED       1
`define IRQ_ENCODER     2
`define IRQ_POSITION    3
`define IRQ_RAMP_DONE   4
// fault log cause bits
`define CAUSE_HW        0
`define CAUSE_FW        1
`define CAUSE_CFG       2
`define CAUSE_ENC       3
// reset values
`define RST_WORD        32'h0000_0000
// timebase: 200 MHz clock, 1000 ns per microsecond tick
`define CLK_PERIOD_NS   5
`define US_NS           1000
`define US_CYCLES       (`US_NS / `CLK_PERIOD_NS)
`endif

/* hdl/safety_sup_pkg.sv */
package safety_sup_pkg;
    typedef struct packed {
        logic torqueOff;
        logic torqueOffSingleChannel;
        logic operationStopMonitor;
        logic stopCategoryOne;
        logic stopCategoryTwo;
        logic limitedSpeed1;
        logic limitedSpeed2;
        logic limitedSpeed3;
        logic limitedSpeed4;
        logic maximumSpeed;
        logic directionMonitor;
        logic limitedIncrement;
        logic brakeControl;
        logic limitedPosition;
        logic maximumPosition;
    } func_req_t;

    typedef struct packed {
        logic signed [31:0] speed;
        logic signed [31:0] speedRef;
        logic signed [31:0] position;
        logic signed [31:0] positionRef;
    } axis_meas_t;

    typedef struct packed {
        logic pulseDisableHigh;
        logic pulseDisableLow;
        logic brakeOut;
    } drive_out_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_OPERATIONAL,
        ST_FAILSAFE
    } sup_state_t;

    typedef enum logic [1:0] {
        RAMP_OFF,
        RAMP_DELAY,
        RAMP_RUN,
        RAMP_END
    } ramp_state_t;
endpackage

/* hdl/drive_safety_function_supervisor.sv */
// Summary of operation
// - ramp check starts after configured delay
// - direction monitor activates after own delay
// - brake control activates after own delay
// - position window starts after configured delay
// - speed below target long enough ends ramp
// - encoder break from lag and speed tolerances
// - monitor lowest of active speed limits while max speed or a ramp function is requested
// - bad limit ordering forces fail-safe
// - no activation or axis id: outputs low
// - hw/fw fault: latched fail-safe, cause logged
// - encoder-free functions skip encoder need
// - fail-safe keeps pulses disabled, brake low
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "safety_sup_defines.svh"

module delay_timer (
    // clock and control
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        usTick,
    // request and result
    input  wire logic        req,
    input  wire logic [31:0] delayUs,
    output logic             active
);
    logic [31:0] cnt_q, cnt_d;
    logic        act_q, act_d;

    always_comb begin
        cnt_d = cnt_q;
        act_d = act_q;
        if (!req) begin
            cnt_d = 32'h0000_0000;
            act_d = 1'b0;
        end else if (!act_q) begin
            if (cnt_q >= delayUs) begin
                act_d = 1'b1;
            end else if (usTick) begin
                cnt_d = cnt_q + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q <= `RST_WORD;
            act_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= cnt_d;
            act_q <= act_d;
        end
    end

    assign active = act_q;
endmodule

module drive_safety_function_supervisor (
    // clock, reset, enable
    input  wire logic                       clk,
    input  wire logic                       srst,
    input  wire logic                       ce,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // safety controller pins
    input  wire logic                       activateIn,
    input  wire logic                       axisIdentityValid,
    input  wire safety_sup_pkg::func_req_t  funcReq,
    // measurement and hardware fault
    input  wire safety_sup_pkg::axis_meas_t meas,
    input  wire logic                       hwFault,
    // drive outputs and interrupt
    output safety_sup_pkg::drive_out_t      driveOut,
    output logic                            irq
);
    import safety_sup_pkg::*;

    // pin inputs: two-stage synchronisers
    logic        actS1_q, actS2_q, idS1_q, idS2_q, hwS1_q, hwS2_q;
    func_req_t   reqS1_q, reqS2_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            actS1_q <= 1'b0;
            actS2_q <= 1'b0;
            idS1_q  <= 1'b0;
            idS2_q  <= 1'b0;
            hwS1_q  <= 1'b0;
            hwS2_q  <= 1'b0;
            reqS1_q <= '0;
            reqS2_q <= '0;
        end else if (ce) begin
            actS1_q <= activateIn;
            actS2_q <= actS1_q;
            idS1_q  <= axisIdentityValid;
            idS2_q  <= idS1_q;
            hwS1_q  <= hwFault;
            hwS2_q  <= hwS1_q;
            reqS1_q <= funcReq;
            reqS2_q <= reqS1_q;
        end
    end

    // microsecond timebase
    logic [7:0] pre_q, pre_d;
    logic       usTick;
    assign usTick = (pre_q == 8'(`US_CYCLES - 1));
    always_comb begin
        pre_d = usTick ? 8'h00 : pre_q + 8'h01;
    end

    // configuration registers
    logic [31:0] ctrl_q, ctrl_d, mask_q, mask_d, ist_q, ist_d, log_q, log_d;
    logic [31:0] cfg_q [0:17];
    logic [31:0] cfg_d [0:17];
    logic        apbWr, apbRd;
    logic [4:0]  idx;
    assign apbWr  = psel && penable && pwrite;
    assign apbRd  = psel && penable && !pwrite;
    assign idx    = paddr[6:2];
    assign pready = 1'b1;
    logic mapped;
    assign mapped = (paddr[1:0] == 2'b00) && (paddr <= `OFF_FAULT_LOG);
    assign pslverr = psel && penable && !mapped;

    // cfg index map: offset/4 - 4
    logic [31:0] dlyRamp, dlyDir, dlyBrake, dlyPos, earlyT, encPosTol, encSpdTol;
    logic signed [31:0] limStand, limLs4, limLs3, limLs2, limLs1, limMax, limNorm;
    logic signed [31:0] maxpLo, limpLo, limpHi, maxpHi;
    assign dlyRamp   = cfg_q[0];
    assign dlyDir    = cfg_q[1];
    assign dlyBrake  = cfg_q[2];
    assign dlyPos    = cfg_q[3];
    assign earlyT    = cfg_q[4];
    assign encPosTol = cfg_q[5];
    assign encSpdTol = cfg_q[6];
    assign limStand  = cfg_q[7];
    assign limLs4    = cfg_q[8];
    assign limLs3    = cfg_q[9];
    assign limLs2    = cfg_q[10];
    assign limLs1    = cfg_q[11];
    assign limMax    = cfg_q[12];
    assign limNorm   = cfg_q[13];
    assign maxpLo    = cfg_q[14];
    assign limpLo    = cfg_q[15];
    assign limpHi    = cfg_q[16];
    assign maxpHi    = cfg_q[17];

    logic cfgValid, fwFault, operated;
    assign cfgValid = ctrl_q[`CTRL_CFG_VALID];
    assign fwFault  = ctrl_q[`CTRL_FW_FAULT];
    assign operated = actS2_q && idS2_q;

    // limit ordering check, only once configuration is declared complete
    logic orderBad;
    assign orderBad = cfgValid && !((limStand <= limLs4) && (limLs4 <= limLs3) && (limLs3 <= limLs2)
                      && (limLs2 <= limLs1) && (limLs1 <= limMax) && (limMax < limNorm)
                      && (maxpLo <= limpLo) && (limpLo <= limpHi) && (limpHi <= maxpHi));

    // delayed function activation
    logic rampReq, rampAct, dirAct, brakeAct, posAct;
    assign rampReq = reqS2_q.stopCategoryOne || reqS2_q.stopCategoryTwo || reqS2_q.limitedSpeed1
                     || reqS2_q.limitedSpeed2 || reqS2_q.limitedSpeed3 || reqS2_q.limitedSpeed4;
    delay_timer uRamp (.clk(clk), .srst(srst), .ce(ce), .usTick(usTick),
        .req(rampReq && operated), .delayUs(dlyRamp), .active(rampAct));
    delay_timer uDir (.clk(clk), .srst(srst), .ce(ce), .usTick(usTick),
        .req(reqS2_q.directionMonitor && operated), .delayUs(dlyDir), .active(dirAct));
    delay_timer uBrake (.clk(clk), .srst(srst), .ce(ce), .usTick(usTick),
        .req(reqS2_q.brakeControl && operated), .delayUs(dlyBrake), .active(brakeAct));
    delay_timer uPos (.clk(clk), .srst(srst), .ce(ce), .usTick(usTick),
        .req(reqS2_q.limitedPosition && operated), .delayUs(dlyPos), .active(posAct));

    // lowest active speed limit; stop functions target standstill
    logic signed [31:0] activeLim;
    logic               limActive;
    always_comb begin
        activeLim = limNorm;
        limActive = 1'b0;
        if (reqS2_q.maximumSpeed) begin
            activeLim = limMax;
            limActive = 1'b1;
        end
        if (reqS2_q.limitedSpeed1 && limLs1 < activeLim) activeLim = limLs1;
        if (reqS2_q.limitedSpeed2 && limLs2 < activeLim) activeLim = limLs2;
        if (reqS2_q.limitedSpeed3 && limLs3 < activeLim) activeLim = limLs3;
        if (reqS2_q.limitedSpeed4 && limLs4 < activeLim) activeLim = limLs4;
        if ((reqS2_q.stopCategoryOne || reqS2_q.stopCategoryTwo || reqS2_q.operationStopMonitor)
            && limStand < activeLim) activeLim = limStand;
        if (rampReq) limActive = 1'b1;
    end

    logic [31:0] absSpeed, spdErr, posErr;
    assign absSpeed = meas.speed[31] ? 32'(-meas.speed) : meas.speed;
    assign spdErr   = (meas.speed > meas.speedRef) ? 32'(meas.speed - meas.speedRef)
                                                   : 32'(meas.speedRef - meas.speed);
    assign posErr   = (meas.position > meas.positionRef) ? 32'(meas.position - meas.positionRef)
                                                         : 32'(meas.positionRef - meas.position);

    // encoder needed by all functions but torque off, single-channel torque off and brake control; stop 1 needs it via the ramp
    logic encNeeded, encBreak;
    assign encNeeded = reqS2_q.operationStopMonitor || reqS2_q.stopCategoryTwo || rampReq
                       || reqS2_q.maximumSpeed || reqS2_q.directionMonitor || reqS2_q.limitedIncrement
                       || reqS2_q.limitedPosition || reqS2_q.maximumPosition;
    assign encBreak  = encNeeded && ((posErr > encPosTol) || (spdErr > encSpdTol));

    // ramp supervision with early end
    ramp_state_t rs_q, rs_d;
    logic [31:0] low_q, low_d;
    logic        rampDone, speedViol, posViol;
    always_comb begin
        rs_d     = rs_q;
        low_d    = low_q;
        rampDone = 1'b0;
        case (rs_q)
            RAMP_OFF:   if (rampReq) rs_d = RAMP_DELAY;
            RAMP_DELAY: if (!rampReq) rs_d = RAMP_OFF;
                        else if (rampAct) rs_d = RAMP_RUN;
            RAMP_RUN: begin
                if (!rampReq) begin
                    rs_d = RAMP_OFF;
                end else if ($signed(absSpeed) >= activeLim) begin
                    low_d = 32'h0000_0000;
                end else if (low_q >= earlyT) begin
                    rs_d     = RAMP_END;
                    rampDone = 1'b1;
                end else if (usTick) begin
                    low_d = low_q + 32'h0000_0001;
                end
            end
            RAMP_END:   if (!rampReq) rs_d = RAMP_OFF;
            default:    rs_d = RAMP_OFF;
        endcase
        if (rs_d != RAMP_RUN) low_d = 32'h0000_0000;
    end
    // limit enforced outside ramp phases only; ramp itself only waits for speed below the limit, with no violation of its own
    assign speedViol = limActive && (rs_q != RAMP_DELAY) && (rs_q != RAMP_RUN)
                       && ($signed(absSpeed) > activeLim);
    assign posViol   = posAct && ((meas.position < limpLo) || (meas.position > limpHi));

    // supervisor state
    sup_state_t st_q, st_d;
    logic       anyFault;
    logic [31:0] cause;
    always_comb begin
        cause = 32'h0000_0000;
        cause[`CAUSE_HW]  = hwS2_q;
        cause[`CAUSE_FW]  = fwFault;
        cause[`CAUSE_CFG] = orderBad;
        cause[`CAUSE_ENC] = encBreak;
    end
    assign anyFault = hwS2_q || fwFault || orderBad || encBreak;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE:        if (anyFault) st_d = ST_FAILSAFE;
                            else if (operated && cfgValid) st_d = ST_OPERATIONAL;
            ST_OPERATIONAL: if (anyFault) st_d = ST_FAILSAFE;
                            else if (!operated) st_d = ST_IDLE;
            ST_FAILSAFE:    st_d = ST_FAILSAFE;
            default:        st_d = ST_FAILSAFE;
        endcase
    end

    // outputs: high level = enable pulses / release brake
    drive_out_t out_d, out_q;
    always_comb begin
        out_d = '0;
        if (st_q == ST_OPERATIONAL && !reqS2_q.torqueOff) begin
            out_d.pulseDisableHigh = 1'b1;
            out_d.pulseDisableLow  = !reqS2_q.torqueOffSingleChannel;
            out_d.brakeOut         = !brakeAct;
        end
        // failsafe and not-operated leave all outputs at 0 V
    end

    // register file
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        cfg_d  = cfg_q;
        log_d  = log_q;
        ist_d  = ist_q;
        if (st_q != ST_FAILSAFE && st_d == ST_FAILSAFE) log_d = cause;
        if (apbWr && mapped) begin
            case (paddr)
                `OFF_CTRL:     ctrl_d = pwdata;
                `OFF_IRQ_STAT: ist_d  = ist_q & ~pwdata;
                `OFF_IRQ_MASK: mask_d = pwdata;
                default:       if (idx >= 5'd4 && idx <= 5'd21) cfg_d[idx - 5'd4] = pwdata;
            endcase
        end
        if (st_d == ST_FAILSAFE) ist_d[`IRQ_FAILSAFE] = 1'b1;
        if (speedViol)           ist_d[`IRQ_SPEED]    = 1'b1;
        if (encBreak)            ist_d[`IRQ_ENCODER]  = 1'b1;
        if (posViol)             ist_d[`IRQ_POSITION] = 1'b1;
        if (rampDone)            ist_d[`IRQ_RAMP_DONE] = 1'b1;
        // config frozen once valid, keeps a checked set from changing under monitoring
        if (cfgValid) cfg_d = cfg_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pre_q  <= 8'h00;
            ctrl_q <= `RST_WORD;
            mask_q <= `RST_WORD;
            ist_q  <= `RST_WORD;
            log_q  <= `RST_WORD;
            for (int i = 0; i < 18; i++) cfg_q[i] <= `RST_WORD;
            rs_q   <= RAMP_OFF;
            low_q  <= `RST_WORD;
            st_q   <= ST_IDLE;
            out_q  <= '0;
        end else if (ce) begin
            pre_q  <= pre_d;
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            ist_q  <= ist_d;
            log_q  <= log_d;
            cfg_q  <= cfg_d;
            rs_q   <= rs_d;
            low_q  <= low_d;
            st_q   <= st_d;
            out_q  <= out_d;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (apbRd && mapped) begin
            case (paddr)
                `OFF_CTRL:      prdata = ctrl_q;
                `OFF_STATUS:    prdata = {22'h0, posAct, brakeAct, dirAct, rampAct, rs_q, st_q, operated, orderBad};
                `OFF_IRQ_STAT:  prdata = ist_q;
                `OFF_IRQ_MASK:  prdata = mask_q;
                `OFF_FAULT_LOG: prdata = log_q;
                default:        prdata = cfg_q[idx - 5'd4];
            endcase
        end
    end

    assign driveOut = out_q;
    assign irq      = |(ist_q & mask_q);
endmodule

/* verification/drive_safety_function_supervisor_properties.sv */
`timescale 1ns/10ps
`include "safety_sup_defines.svh"
module supervisor_checker
    import safety_sup_pkg::*;
(
    // clock and reset
    input wire logic                      clk,
    input wire logic                      srst,
    // apb
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pready,
    input wire logic                      pslverr,
    // controller pins and faults
    input wire logic                      activateIn,
    input wire logic                      axisIdentityValid,
    input wire safety_sup_pkg::func_req_t funcReq,
    input wire logic                      hwFault,
    // outputs
    input wire safety_sup_pkg::drive_out_t driveOut,
    input wire logic                      irq
);
    import safety_sup_pkg::*;
    logic        wrEn, frozen_q, frozen_d, maskZero_q, maskZero_d;
    logic [31:0] brakeDly_q, brakeDly_d, brkCnt_q, brkCnt_d;
    logic [5:0]  hwDly_q, hwDly_d;
    int          brkLo;

    // shadow of the config writes, so delays can be checked at the pins
    always_comb begin
        wrEn = psel && penable && pwrite && pready;
        frozen_d = (wrEn && paddr == `OFF_CTRL) ? pwdata[`CTRL_CFG_VALID] : frozen_q;
        brakeDly_d = (wrEn && paddr == `OFF_DLY_BRAKE && !frozen_q) ? pwdata : brakeDly_q;
        maskZero_d = (wrEn && paddr == `OFF_IRQ_MASK) ? (pwdata[4:0] == 5'h0) : maskZero_q;
        brkCnt_d = (funcReq.brakeControl && activateIn && axisIdentityValid) ? brkCnt_q + 32'h1 : 32'h0;
        hwDly_d = {hwDly_q[4:0], hwDly_q[0] | hwFault};
        brkLo = int'(brakeDly_q) * `US_CYCLES;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            frozen_q <= 1'b0;
            maskZero_q <= 1'b1;
            brakeDly_q <= 32'h0;
            brkCnt_q <= 32'h0;
            hwDly_q <= 6'h0;
        end else begin
            frozen_q <= frozen_d;
            maskZero_q <= maskZero_d;
            brakeDly_q <= brakeDly_d;
            brkCnt_q <= brkCnt_d;
            hwDly_q <= hwDly_d;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_idle_outputs_safe: assert property (
        (!(activateIn && axisIdentityValid)) [*6] |-> driveOut == 3'h0) else $error("outputs live while not operated");
    a_hw_fault_latched: assert property (
        hwDly_q[5] |-> driveOut == 3'h0) else $error("outputs live after hardware fault");
    // the tick may be free running, so one microsecond of slack below
    a_brake_delay_kept: assert property (
        $fell(driveOut.brakeOut) && funcReq.brakeControl && !hwDly_q[0]
        |-> int'(brkCnt_q) + `US_CYCLES >= brkLo && int'(brkCnt_q) <= brkLo + 16) else $error("brake delay off");
    a_torque_off_pulses: assert property (
        funcReq.torqueOff [*6] |-> !driveOut.pulseDisableHigh && !driveOut.pulseDisableLow)
        else $error("pulses enabled under torque off");
    a_single_low_cleared: assert property (
        funcReq.torqueOffSingleChannel [*6] |-> !driveOut.pulseDisableLow) else $error("low channel still on");
    a_mask_blocks_irq: assert property (
        maskZero_q && $past(maskZero_q) |-> !irq) else $error("irq with empty mask");
    a_unmapped_flags_error: assert property (
        psel && penable && (paddr > `OFF_FAULT_LOG || paddr[1:0] != 2'h0) |-> pslverr) else $error("no slave error");
    a_unmapped_reads_zero: assert property (
        psel && penable && !pwrite && paddr > `OFF_FAULT_LOG |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_ready_in_access: assert property (
        psel && penable |-> pready) else $error("access without ready");
endmodule

bind drive_safety_function_supervisor supervisor_checker chk (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .activateIn(activateIn),
    .axisIdentityValid(axisIdentityValid), .funcReq(funcReq), .hwFault(hwFault), .driveOut(driveOut), .irq(irq)
);

/* verification/safety_ctrl_model.sv */
`timescale 1ns/10ps
module safety_ctrl_model
    import safety_sup_pkg::*;
(
    // commands from the bench
    input  wire logic                      clk,
    input  wire logic                      wantActive,
    input  wire logic                      wantId,
    input  wire safety_sup_pkg::func_req_t wantReq,
    // pins towards the supervisor
    output logic                           activateIn,
    output logic                           axisIdentityValid,
    output safety_sup_pkg::func_req_t      funcReq
);
    import safety_sup_pkg::*;
    logic      active_q, active_d, id_q, id_d;
    func_req_t req_q, req_d;

    always_comb begin
        active_d = wantActive;
        id_d = wantId;
        // requests not commanded stay low, as an open input would
        req_d = wantReq;
    end

    always_ff @(posedge clk) begin
        active_q <= active_d;
        id_q <= id_d;
        req_q <= req_d;
    end

    assign activateIn = active_q;
    assign axisIdentityValid = id_q;
    assign funcReq = req_q;
endmodule

/* verification/drive_safety_function_supervisor_tb_top.sv */
`timescale 1ns/10ps
`include "safety_sup_defines.svh"
module drive_safety_function_supervisor_tb_top;
    import safety_sup_pkg::*;
    logic        clk, srst, psel, penable, pwrite, pready, pslverr, irq, hwFault;
    logic        wantActive, wantId, activateIn, axisIdentityValid, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, wval;
    func_req_t   funcReq, wantReq;
    axis_meas_t  meas;
    drive_out_t  driveOut;
    int          bad_count, checks, seed, tw, tReq;
    int          cyc = 0;

    safety_ctrl_model ctrl (.clk(clk), .wantActive(wantActive), .wantId(wantId), .wantReq(wantReq),
        .activateIn(activateIn), .axisIdentityValid(axisIdentityValid), .funcReq(funcReq));
    drive_safety_function_supervisor dut (.clk(clk), .srst(srst), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .activateIn(activateIn), .axisIdentityValid(axisIdentityValid), .funcReq(funcReq), .meas(meas),
        .hwFault(hwFault), .driveOut(driveOut), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    task automatic end_sim;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic int expCycles(input int us);
        return us * `US_CYCLES;
    endfunction

    // free running tick allows one microsecond early, polling adds a few cycles late
    task automatic cmpWin(input int t, input int us);
        checks++;
        if (t < expCycles(us - 1) || t > expCycles(us) + 24) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, t, expCycles(us));
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic waitReg(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v);
        rdat = ~v;
        for (int i = 0; i < 3000 && (rdat & m) !== v; i++) apb(1'b0, a, 32'h0);
        tw = cyc - tReq;
    endtask

    task automatic doReset;
        srst <= 1'b1;
        hwFault <= 1'b0;
        wantReq <= '0;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
    endtask

    // delays 2..5 us, early time 2 us, limits ordered, windows nested
    task automatic configure(input logic bad);
        logic [31:0] cfg [18];
        cfg = '{32'h2, 32'h3, 32'h4, 32'h5, 32'h2, 32'h32, 32'h32, 32'h0A, 32'h64, 32'hC8, 32'h1F4, 32'h3E8,
                32'h7D0, 32'hBB8, 32'hFFFF_FC18, 32'hFFFF_FF9C, 32'h64, 32'h3E8};
        if (bad) cfg[10] = 32'hFA0;
        for (int i = 0; i < 18; i++) apb(1'b1, 12'(`OFF_DLY_RAMP + 4 * i), cfg[i]);
        apb(1'b1, `OFF_CTRL, 32'h1);
    endtask

    initial begin
        #(`CLK_PERIOD_NS * 60000);
        bad_count++;
        end_sim();
    end

    initial begin
        seed = 11549;
        {srst, psel, penable, pwrite, hwFault, wantActive, wantId} = 7'h40;
        {paddr, pwdata, wantReq, meas} = '0;
        doReset();
        for (int a = 0; a <= `OFF_FAULT_LOG; a += 4) begin
            apb(1'b0, 12'(a), 32'h0);
            cmp(rdat, `RST_WORD);
        end
        apb(1'b0, 12'h05C, 32'h0);
        cmp({perr, rdat[30:0]}, 32'h8000_0000);
        for (int a = `OFF_DLY_RAMP; a <= `OFF_MAXP_HI; a += 4) begin
            wval = $random(seed);
            apb(1'b1, 12'(a), wval);
            apb(1'b0, 12'(a), 32'h0);
            cmp(rdat, wval);
        end
        $display("test registers done");
        for (int p = 0; p < 2; p++) begin
            wantActive <= p[0];
            wantId <= !p[0];
            repeat (100) begin
                @(posedge clk);
                wantReq <= func_req_t'(15'($random(seed)));
                meas.speed <= $random(seed);
            end
            cmp({29'h0, driveOut}, 32'h0);
        end
        // random idle phase may latch an encoder fail-safe
        doReset();
        meas <= '{32'h2BC, 32'h2BC, 32'h0, 32'h0};
        configure(1'b0);
        wantActive <= 1'b1;
        wantId <= 1'b1;
        repeat (10) @(posedge clk);
        cmp({29'h0, driveOut}, 32'h7);
        apb(1'b0, `OFF_STATUS, 32'h0);
        cmp(rdat & 32'hF, {28'h0, ST_OPERATIONAL, 2'b10});
        for (int k = 0; k < 2; k++) begin
            wantReq.torqueOff <= (k == 0);
            wantReq.torqueOffSingleChannel <= (k == 1);
            repeat (10) @(posedge clk);
            cmp({29'h0, driveOut}, k ? 32'h5 : 32'h0);
        end
        wantReq <= '0;
        $display("test operation done");
        repeat (10) @(posedge clk);
        {wantReq.limitedSpeed1, wantReq.limitedSpeed2, wantReq.directionMonitor} <= 3'h7;
        {wantReq.brakeControl, wantReq.limitedPosition} <= 2'h3;
        tReq = cyc;
        for (int i = 0; i < 4; i++) begin
            waitReg(`OFF_STATUS, 32'h1 << (6 + i), 32'h1 << (6 + i));
            cmpWin(tw, i + 2);
        end
        cmp({31'h0, driveOut.brakeOut}, 32'h0);
        // 700 lies between the two active limits: only the lower one may count
        apb(1'b0, `OFF_STATUS, 32'h0);
        cmp(rdat & 32'h30, {26'h0, RAMP_RUN, 4'h0});
        meas <= '{32'h12C, 32'h12C, 32'h0, 32'h0};
        tReq = cyc;
        waitReg(`OFF_STATUS, 32'h30, {26'h0, RAMP_END, 4'h0});
        cmpWin(tw, 2);
        apb(1'b1, `OFF_IRQ_MASK, 32'h10);
        repeat (3) @(posedge clk);
        cmp({31'h0, irq}, 32'h1);
        apb(1'b1, `OFF_IRQ_STAT, 32'h10);
        apb(1'b1, `OFF_IRQ_MASK, 32'h0);
        apb(1'b0, `OFF_IRQ_STAT, 32'h0);
        cmp(rdat & 32'h10, 32'h0);
        $display("test delays done");
        for (int k = 0; k < 4; k++) begin
            doReset();
            configure(k == 2);
            apb(1'b1, `OFF_IRQ_MASK, 32'h1);
            wantReq.limitedSpeed1 <= 1'b1;
            repeat (10) @(posedge clk);
            if (k == 0) hwFault <= 1'b1;
            if (k == 1) apb(1'b1, `OFF_CTRL, 32'h3);
            if (k == 3) meas.positionRef <= 32'h1000;
            repeat (20) @(posedge clk);
            hwFault <= 1'b0;
            meas.positionRef <= 32'h0;
            repeat (20) @(posedge clk);
            cmp({29'h0, driveOut}, 32'h0);
            cmp({31'h0, irq}, 32'h1);
            apb(1'b0, `OFF_FAULT_LOG, 32'h0);
            cmp(rdat, 32'h1 << k);
            apb(1'b0, `OFF_STATUS, 32'h0);
            cmp(rdat & 32'hC, {28'h0, ST_FAILSAFE, 2'b00});
        end
        $display("test fail-safe done");
        end_sim();
    end
endmodule
